// >>> hw/dbtc_defs.svh
// register indices, control bit positions and reset values of the timer
`ifndef DBTC_DEFS_SVH
`define DBTC_DEFS_SVH

// register indices; byte address is four times the index
`define DBTC_IDX_CTRL  16'hFE10
`define DBTC_IDX_PRR   16'hFE11
`define DBTC_IDX_LCNT  16'hFE12
`define DBTC_IDX_HCNT  16'hFE13
`define DBTC_IDX_LDATA 16'hFE14
`define DBTC_IDX_HDATA 16'hFE15
`define DBTC_IDX_LCAPA 16'hFE16
`define DBTC_IDX_HCAPA 16'hFE17
`define DBTC_IDX_LCAPB 16'hFE1E
`define DBTC_IDX_HCAPB 16'hFE1F

// control register bit positions
`define DBTC_B_HRUN  7
`define DBTC_B_LRUN  6
`define DBTC_B_WIDE  5
`define DBTC_B_LEXT  4
`define DBTC_B_HFLAG 3
`define DBTC_B_HIE   2
`define DBTC_B_LFLAG 1
`define DBTC_B_LIE   0

// reset values and counting constants
`define DBTC_RST_BYTE 8'h00
`define DBTC_RST_WORD 32'h0000_0000
`define DBTC_ONE      8'h01
`define DBTC_TOP      8'hFF

`endif

// >>> hw/dbtc_pkg.sv
// types and mode decode of the dual byte timer
package dbtc_pkg;

   typedef enum logic [1:0]
   {
      DBTC_MODE_DUAL     = 2'b00,
      DBTC_MODE_EXT_LOW  = 2'b01,
      DBTC_MODE_WIDE_PRE = 2'b10,
      DBTC_MODE_WIDE_EXT = 2'b11
   } dbtc_mode_t;

   function automatic dbtc_mode_t dbtc_mode(input logic wide, input logic ext);
      return dbtc_mode_t'({wide, ext});
   endfunction

   function automatic logic dbtc_hit(input logic [15:0] idx, input logic [15:0] target);
      return idx == target;
   endfunction

endpackage

// >>> hw/dbtc_timer.sv
// dual byte timer/counter with prescaler, match buffers and captures
//
// Contract
// - prescaler counts every cycle except hold
// - prescaler pulses on match, period value+1
// - prescaler restarts on match or write
// - run bits 6 and 7 gate counting
// - bit 4 picks low clock source
// - bit 5 picks high clock source
// - wide mode matches all sixteen bits
// - bits 5 and 4 decode four modes
// - byte mode each byte matches own buffer
// - counter clears on match, zero when stopped
// - buffer follows data stopped, reloads on match
// - match flags sticky until software clears
// - wide match sets both flags together while bit 7 runs, low flag only otherwise
// - high enable and flag request interrupt
// - low enable and flag request interrupt
// - low capture a source follows bit 5
// - high capture a on high input
// - low capture b source follows bit 5
// - high capture b on second high input
// - low count read only
`timescale 1ns/1ps
`include "dbtc_defs.svh"

module dbtc_timer
   import dbtc_pkg::*;
#(
   parameter int ADR_W = 18
)
(
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rstn,
   // wishbone slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // power state
   input  wire logic             hold_i,
   // detected pin events, one cycle each
   input  wire logic             external_count_input,
   input  wire logic             low_capture_input,
   input  wire logic             high_capture_input,
   input  wire logic             second_low_capture_input,
   input  wire logic             second_high_capture_input,
   // interrupt requests
   output logic                  high_irq_o,
   output logic                  low_irq_o
);

   logic [7:0]  ctrl_reg;
   logic [7:0]  ctrl_next;
   logic [7:0]  prr_reg;
   logic [7:0]  pres_reg;
   logic [7:0]  lo_reg;
   logic [7:0]  lo_next;
   logic [7:0]  hi_reg;
   logic [7:0]  hi_next;
   logic [7:0]  ldata_reg;
   logic [7:0]  hdata_reg;
   logic [7:0]  lbuf_reg;
   logic [7:0]  hbuf_reg;
   logic [7:0]  lcapa_reg;
   logic [7:0]  hcapa_reg;
   logic [7:0]  lcapb_reg;
   logic [7:0]  hcapb_reg;
   logic [7:0]  rd_next;
   logic        ack_reg;
   logic [31:0] dat_reg;
   logic        hirq_reg;
   logic        lirq_reg;
   logic [15:0] idx;
   logic        wb_req;
   logic        wr_commit;
   logic        wr_ctrl;
   logic        wr_prr;
   logic        wr_ldata;
   logic        wr_hdata;
   dbtc_mode_t  mode;
   logic        wide;
   logic        ext_sel;
   logic        run_lo;
   logic        run_hi;
   logic        pres_match;
   logic        lo_tick;
   logic        hi_tick;
   logic        lo_hit;
   logic        hi_hit;
   logic        wide_hit;
   logic        lo_match;
   logic        hi_match;

   // bus decode
   assign idx       = wb_adr_i[17:2];
   assign wb_req    = wb_cyc_i & wb_stb_i;
   assign wr_commit = wb_req & wb_we_i & ack_reg & wb_sel_i[0];
   assign wr_ctrl   = wr_commit & dbtc_hit(idx, `DBTC_IDX_CTRL);
   assign wr_prr    = wr_commit & dbtc_hit(idx, `DBTC_IDX_PRR);
   assign wr_ldata  = wr_commit & dbtc_hit(idx, `DBTC_IDX_LDATA);
   assign wr_hdata  = wr_commit & dbtc_hit(idx, `DBTC_IDX_HDATA);

   // mode decode
   assign mode    = dbtc_mode(ctrl_reg[`DBTC_B_WIDE], ctrl_reg[`DBTC_B_LEXT]);
   assign wide    = (mode == DBTC_MODE_WIDE_PRE) | (mode == DBTC_MODE_WIDE_EXT);
   assign ext_sel = (mode == DBTC_MODE_EXT_LOW) | (mode == DBTC_MODE_WIDE_EXT);
   assign run_lo  = ctrl_reg[`DBTC_B_LRUN];
   assign run_hi  = ctrl_reg[`DBTC_B_HRUN];

   // prescaler
   assign pres_match = ~hold_i & (pres_reg == prr_reg);

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         pres_reg <= `DBTC_RST_BYTE;
      else if (wr_prr | pres_match)
         pres_reg <= `DBTC_RST_BYTE;
      else if (!hold_i)
         pres_reg <= pres_reg + `DBTC_ONE;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         prr_reg <= `DBTC_RST_BYTE;
      else if (wr_prr)
         prr_reg <= wb_dat_i[7:0];
   end

   // count sources and matches
   assign lo_tick  = run_lo & ~hold_i & (ext_sel ? external_count_input : pres_match);
   assign hi_tick  = run_hi & pres_match;
   assign lo_hit   = lo_reg == lbuf_reg;
   assign hi_hit   = hi_reg == hbuf_reg;
   assign wide_hit = {hi_reg, lo_reg} == {hbuf_reg, lbuf_reg};
   assign lo_match = wide ? (lo_tick & wide_hit) : (lo_tick & lo_hit);
   assign hi_match = wide ? (lo_tick & wide_hit & run_hi) : (hi_tick & hi_hit);

   always_comb
   begin
      lo_next = lo_reg;
      hi_next = hi_reg;
      if (wide)
      begin
         if (lo_tick)
         begin
            if (wide_hit)
            begin
               lo_next = `DBTC_RST_BYTE;
               hi_next = `DBTC_RST_BYTE;
            end
            else
            begin
               lo_next = lo_reg + `DBTC_ONE;
               // high byte counts low byte carries
               if (lo_reg == `DBTC_TOP)
                  hi_next = hi_reg + `DBTC_ONE;
            end
         end
      end
      else
      begin
         if (lo_tick)
            lo_next = lo_hit ? `DBTC_RST_BYTE : lo_reg + `DBTC_ONE;
         if (hi_tick)
            hi_next = hi_hit ? `DBTC_RST_BYTE : hi_reg + `DBTC_ONE;
      end
      if (!run_lo)
         lo_next = `DBTC_RST_BYTE;
      if (!run_hi)
         hi_next = `DBTC_RST_BYTE;
   end

   // counters, never written by software
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lo_reg <= `DBTC_RST_BYTE;
         hi_reg <= `DBTC_RST_BYTE;
      end
      else
      begin
         lo_reg <= lo_next;
         hi_reg <= hi_next;
      end
   end

   // match data
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ldata_reg <= `DBTC_RST_BYTE;
         hdata_reg <= `DBTC_RST_BYTE;
      end
      else
      begin
         if (wr_ldata)
            ldata_reg <= wb_dat_i[7:0];
         if (wr_hdata)
            hdata_reg <= wb_dat_i[7:0];
      end
   end

   // match buffers
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lbuf_reg <= `DBTC_RST_BYTE;
         hbuf_reg <= `DBTC_RST_BYTE;
      end
      else
      begin
         if (!run_lo | lo_match)
            lbuf_reg <= ldata_reg;
         if (!run_hi | hi_match)
            hbuf_reg <= hdata_reg;
      end
   end

   // control with sticky flags, hardware set beats a software clear
   always_comb
   begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl)
         ctrl_next = wb_dat_i[7:0];
      if (hi_match)
         ctrl_next[`DBTC_B_HFLAG] = 1'b1;
      if (lo_match)
         ctrl_next[`DBTC_B_LFLAG] = 1'b1;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         ctrl_reg <= `DBTC_RST_BYTE;
      else
         ctrl_reg <= ctrl_next;
   end

   // interrupt requests, aligned with the flags
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hirq_reg <= 1'b0;
         lirq_reg <= 1'b0;
      end
      else
      begin
         // toward vector 0023H
         hirq_reg <= ctrl_next[`DBTC_B_HIE] & ctrl_next[`DBTC_B_HFLAG];
         // toward vector 0013H
         lirq_reg <= ctrl_next[`DBTC_B_LIE] & ctrl_next[`DBTC_B_LFLAG];
      end
   end

   // captures sample the count before this cycle's update
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         lcapa_reg <= `DBTC_RST_BYTE;
         hcapa_reg <= `DBTC_RST_BYTE;
         lcapb_reg <= `DBTC_RST_BYTE;
         hcapb_reg <= `DBTC_RST_BYTE;
      end
      else
      begin
         if (wide ? high_capture_input : low_capture_input)
            lcapa_reg <= lo_reg;
         if (high_capture_input)
            hcapa_reg <= hi_reg;
         if (wide ? second_high_capture_input : second_low_capture_input)
            lcapb_reg <= lo_reg;
         if (second_high_capture_input)
            hcapb_reg <= hi_reg;
      end
   end

   // read mux, unmapped reads return zero
   always_comb
   begin
      rd_next = `DBTC_RST_BYTE;
      case (idx)
         `DBTC_IDX_CTRL:  rd_next = ctrl_reg;
         `DBTC_IDX_PRR:   rd_next = prr_reg;
         `DBTC_IDX_LCNT:  rd_next = lo_reg;
         `DBTC_IDX_HCNT:  rd_next = hi_reg;
         `DBTC_IDX_LDATA: rd_next = ldata_reg;
         `DBTC_IDX_HDATA: rd_next = hdata_reg;
         `DBTC_IDX_LCAPA: rd_next = lcapa_reg;
         `DBTC_IDX_HCAPA: rd_next = hcapa_reg;
         `DBTC_IDX_LCAPB: rd_next = lcapb_reg;
         `DBTC_IDX_HCAPB: rd_next = hcapb_reg;
         default:         rd_next = `DBTC_RST_BYTE;
      endcase
   end

   // one wait state answer
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ack_reg <= 1'b0;
         dat_reg <= `DBTC_RST_WORD;
      end
      else
      begin
         ack_reg <= wb_req & ~ack_reg;
         if (wb_req & ~ack_reg)
            dat_reg <= {24'h000000, rd_next};
      end
   end

   assign wb_ack_o   = ack_reg;
   assign wb_dat_o   = dat_reg;
   assign high_irq_o = hirq_reg;
   assign low_irq_o  = lirq_reg;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   property p_pres_step;
      !hold_i && !pres_match && !wr_prr |=> pres_reg == $past(pres_reg) + 8'h01;
   endproperty
   a_pres_step: assert property (p_pres_step)
      else $error("prescaler did not step");

   property p_pres_hold;
      hold_i && !wr_prr |=> $stable(pres_reg);
   endproperty
   a_pres_hold: assert property (p_pres_hold)
      else $error("prescaler moved in hold");

   property p_pres_restart;
      (pres_match || wr_prr) |=> pres_reg == 8'h00;
   endproperty
   a_pres_restart: assert property (p_pres_restart)
      else $error("prescaler did not restart");

   property p_lo_stopped;
      !run_lo |=> lo_reg == 8'h00;
   endproperty
   a_lo_stopped: assert property (p_lo_stopped)
      else $error("stopped low counter not zero");

   property p_lo_idle;
      run_lo && !lo_tick && !$past(wide) |=> lo_reg == $past(lo_reg);
   endproperty
   a_lo_idle: assert property (p_lo_idle)
      else $error("low counter moved without tick");

   property p_buf_follow;
      !run_hi |=> hbuf_reg == $past(hdata_reg);
   endproperty
   a_buf_follow: assert property (p_buf_follow)
      else $error("high buffer not following data");

   property p_lflag_set;
      lo_match |=> ctrl_reg[1] ##1 (ctrl_reg[1] || $past(wr_ctrl));
   endproperty
   a_lflag_set: assert property (p_lflag_set)
      else $error("low match flag not set");

   property p_wide_flags;
      wide && lo_match && run_hi |=> ctrl_reg[3] && ctrl_reg[1] && lo_reg == 8'h00;
   endproperty
   a_wide_flags: assert property (p_wide_flags)
      else $error("wide match did not set both flags");

   property p_high_irq;
      high_irq_o == (ctrl_reg[2] && ctrl_reg[3]);
   endproperty
   a_high_irq: assert property (p_high_irq)
      else $error("high interrupt request wrong");

   property p_low_irq;
      low_irq_o == (ctrl_reg[0] && ctrl_reg[1]);
   endproperty
   a_low_irq: assert property (p_low_irq)
      else $error("low interrupt request wrong");

   property p_cap_high;
      high_capture_input |=> hcapa_reg == $past(hi_reg);
   endproperty
   a_cap_high: assert property (p_cap_high)
      else $error("high capture a wrong value");

   property p_cap_wide_low;
      wide && second_high_capture_input |=> lcapb_reg == $past(lo_reg);
   endproperty
   a_cap_wide_low: assert property (p_cap_wide_low)
      else $error("low capture b wrong in wide mode");

endmodule // dbtc_timer

// >>> tb/dbtc_pin_model.sv
// event pin model: detected one-cycle events toward the timer
`timescale 1ns/1ps

module dbtc_pin_model
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rstn,
   // requested events, bit 0 count, 1 to 4 captures
   input  wire logic [4:0] ev_req,
   // detected event pulses
   output logic      [4:0] ev_out
);
   // a request held one cycle gives exactly one pulse
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         ev_out <= 5'h00;
      else
         ev_out <= ev_req;
   end
endmodule // dbtc_pin_model

// >>> tb/tb.sv
// self-checking bench of the dual byte timer
`timescale 1ns/1ps
`include "dbtc_defs.svh"

module tb;
   logic        core_clk = 1'b0;
   logic        rstn     = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i  = 1'b0;
   logic [17:0] wb_adr_i = 18'h00000;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h00000000;
   logic [31:0] wb_dat_o, rd;
   logic        wb_ack_o, high_irq_o, low_irq_o;
   logic        hold_i   = 1'b0;
   logic [4:0]  ev_req   = 5'h00;
   logic [4:0]  ev;
   int          errors = 0, tests_run = 0, seed = 91932, cyc_cnt = 0, t0, t1, p, l;
   logic [15:0] regs [10] = '{`DBTC_IDX_CTRL, `DBTC_IDX_PRR, `DBTC_IDX_LCNT, `DBTC_IDX_HCNT,
      `DBTC_IDX_LDATA, `DBTC_IDX_HDATA, `DBTC_IDX_LCAPA, `DBTC_IDX_HCAPA, `DBTC_IDX_LCAPB,
      `DBTC_IDX_HCAPB};

   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) cyc_cnt <= cyc_cnt + 1;

   dbtc_timer #(.ADR_W(18)) i_dbtc_timer
   (
      .core_clk(core_clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .hold_i(hold_i),
      .external_count_input(ev[0]), .low_capture_input(ev[1]),
      .high_capture_input(ev[2]), .second_low_capture_input(ev[3]),
      .second_high_capture_input(ev[4]), .high_irq_o(high_irq_o), .low_irq_o(low_irq_o)
   );

   dbtc_pin_model i_dbtc_pin_model
   (
      .core_clk(core_clk), .rstn(rstn), .ev_req(ev_req), .ev_out(ev)
   );

   task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   // expected match period in cycles: (data + 1) * (prescale + 1)
   function automatic int period_of(input int data, input int pre);
      return (data + 1) * (pre + 1);
   endfunction

   // one classic cycle, held until ack is sampled; only the watchdog ends a hang
   task automatic wb(input logic we, input logic [15:0] idx, input logic [7:0] wd);
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_sel_i <= 4'h1;
      wb_adr_i <= {idx, 2'b00};
      wb_dat_i <= {24'h000000, wd};
      do
      begin
         @(posedge core_clk);
      end
      while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rchk(input string name, input logic [15:0] idx, input logic [31:0] exp);
      wb(1'b0, idx, 8'h00);
      chk(name, rd, exp);
   endtask

   // n back-to-back event cycles, then let the pulses land
   task automatic fire(input logic [4:0] pat, input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         ev_req <= pat;
      end
      @(posedge core_clk);
      ev_req <= 5'h00;
      repeat (2) @(posedge core_clk);
   endtask

   task automatic wait_irq(input bit hi, output int t);
      int n;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while ((hi ? high_irq_o : low_irq_o) !== 1'b1 && n < 5000);
      if (n >= 5000)
         errors++;
      t = cyc_cnt;
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      repeat (5) @(posedge core_clk);
      rstn <= 1'b1;
      foreach (regs[i]) rchk("reset value", regs[i], 32'h00000000);
      wb(1'b1, `DBTC_IDX_LCNT, 8'hFF);
      rchk("low count write", `DBTC_IDX_LCNT, 32'h00000000);
      rchk("unmapped", 16'hFE18, 32'h00000000);
      wb(1'b1, `DBTC_IDX_PRR, 8'hA5);
      rchk("prescaler match", `DBTC_IDX_PRR, 32'h000000A5);
      for (int b = 0; b < 2; b++)
         repeat (3)
         begin
            p = 3 + $unsigned($random(seed)) % 8;
            l = 3 + $unsigned($random(seed)) % 8;
            wb(1'b1, b ? `DBTC_IDX_HDATA : `DBTC_IDX_LDATA, l[7:0]);
            wb(1'b1, `DBTC_IDX_CTRL, b ? 8'h84 : 8'h41);
            wb(1'b1, `DBTC_IDX_PRR, p[7:0]);
            wait_irq(b[0], t0);
            wb(1'b1, `DBTC_IDX_CTRL, b ? 8'h84 : 8'h41);
            wait_irq(b[0], t1);
            chk("timer period", t1 - t0, period_of(l, p));
            wb(1'b1, `DBTC_IDX_CTRL, 8'h00);
            rchk("stopped count", b ? `DBTC_IDX_HCNT : `DBTC_IDX_LCNT, 32'h00000000);
         end
      // sixteen-bit prescaled timer, high byte fed by low byte carry
      l = 3 + $unsigned($random(seed)) % 8;
      p = 3 + $unsigned($random(seed)) % 8;
      wb(1'b1, `DBTC_IDX_LDATA, l[7:0]);
      wb(1'b1, `DBTC_IDX_HDATA, 8'h01);
      wb(1'b1, `DBTC_IDX_CTRL, 8'hE5);
      wb(1'b1, `DBTC_IDX_PRR, p[7:0]);
      wait_irq(1'b1, t0);
      chk("wide prescaled low flag", low_irq_o, 32'h00000001);
      wb(1'b1, `DBTC_IDX_CTRL, 8'hE5);
      wait_irq(1'b1, t1);
      chk("wide prescaled period", t1 - t0, period_of(256 + l, p));
      wb(1'b1, `DBTC_IDX_CTRL, 8'h00);
      // external low counting, hold, captures
      wb(1'b1, `DBTC_IDX_LDATA, 8'h04);
      wb(1'b1, `DBTC_IDX_CTRL, 8'h51);
      fire(5'h01, 4);
      chk("low irq early", low_irq_o, 32'h00000000);
      hold_i <= 1'b1;
      fire(5'h01, 3);
      hold_i <= 1'b0;
      rchk("count in hold", `DBTC_IDX_LCNT, 32'h00000004);
      fire(5'h02, 1);
      rchk("low capture a", `DBTC_IDX_LCAPA, 32'h00000004);
      fire(5'h08, 1);
      rchk("low capture b", `DBTC_IDX_LCAPB, 32'h00000004);
      fire(5'h04, 1);
      rchk("high capture a", `DBTC_IDX_HCAPA, 32'h00000000);
      fire(5'h01, 1);
      chk("low irq", low_irq_o, 32'h00000001);
      rchk("count after match", `DBTC_IDX_LCNT, 32'h00000000);
      wb(1'b1, `DBTC_IDX_CTRL, 8'h00);
      // sixteen-bit external counting
      wb(1'b1, `DBTC_IDX_LDATA, 8'h01);
      wb(1'b1, `DBTC_IDX_HDATA, 8'h01);
      wb(1'b1, `DBTC_IDX_CTRL, 8'hF5);
      fire(5'h01, 256);
      rchk("wide high", `DBTC_IDX_HCNT, 32'h00000001);
      chk("no byte match", low_irq_o, 32'h00000000);
      fire(5'h05, 1);
      rchk("capture pre low", `DBTC_IDX_LCAPA, 32'h00000000);
      rchk("capture pre high", `DBTC_IDX_HCAPA, 32'h00000001);
      fire(5'h02, 1);
      rchk("low capture ignored", `DBTC_IDX_LCAPA, 32'h00000000);
      fire(5'h10, 1);
      rchk("low capture b wide", `DBTC_IDX_LCAPB, 32'h00000001);
      rchk("high capture b", `DBTC_IDX_HCAPB, 32'h00000001);
      fire(5'h01, 1);
      chk("both irqs", {high_irq_o, low_irq_o}, 32'h00000003);
      rchk("wide low clear", `DBTC_IDX_LCNT, 32'h00000000);
      rchk("wide high clear", `DBTC_IDX_HCNT, 32'h00000000);
      summarize();
   end

   initial
   begin
      #(25 * 40000);
      errors++;
      summarize();
   end
endmodule // tb
